// ### verilog/asi_defs.vh
// Constants for the appliance status indicator
`ifndef ASI_DEFS_VH
`define ASI_DEFS_VH

// ==========================================
// Clock and time figures
`define ASI_CLK_MHZ        100
`define ASI_MS_CYC         (`ASI_CLK_MHZ * 1000)
`define ASI_BLINK_HALF_MS  500
`define ASI_QUICK_HALF_MS  100
`define ASI_BEEP_MS        100
`define ASI_BURST_S        20
`define ASI_BEEP_MAX_MIN   5
`define ASI_MINUTE_S       60
`define ASI_FLASH_PHASES   3'h6

// ==========================================
// Register word indices (byte address = index * 4)
`define ASI_A_CTRL   3'h0
`define ASI_A_FAULT  3'h1
`define ASI_A_TTE    3'h2
`define ASI_A_STAT   3'h3
`define ASI_A_ISTAT  3'h4
`define ASI_A_IMASK  3'h5
`define ASI_A_CMD    3'h6

// ==========================================
// Control bits
`define ASI_C_LOCK    0
`define ASI_C_XR      1
`define ASI_C_DSPIN   2
`define ASI_C_DLOCK   3
`define ASI_C_UNLK    4
`define ASI_C_PTC     5
`define ASI_C_TOPDSP  6
`define ASI_C_DRUMPOS 7
`define ASI_C_RUN     8
`define ASI_C_PAUSE   9
`define ASI_C_SPLED   10
`define ASI_C_DISP    11
`define ASI_CTRL_RST  12'h000
`define ASI_TTE_RST   11'h000

// ==========================================
// Fault codes written by the main board
`define ASI_F_NONE 3'h0
`define ASI_F_E10  3'h1
`define ASI_F_E20  3'h2
`define ASI_F_E40  3'h3
`define ASI_F_E91  3'h4
`define ASI_F_EH0  3'h5

// ==========================================
// Interrupt bits
`define ASI_I_INV   0
`define ASI_I_FAULT 1
`define ASI_I_CLR   2
`define ASI_I_END   3
`define ASI_I_LOCK  4

// ==========================================
// Display character codes
`define ASI_CH_E     4'ha
`define ASI_CH_R     4'hb
`define ASI_CH_H     4'hc
`define ASI_CH_BLANK 4'hf

`endif

// ### verilog/asi_timebase.v
// Free-running millisecond, blink and quick-flash timebase
`timescale 1ns/1ps
`include "asi_defs.vh"

module asi_timebase #(
  parameter [16:0] MS_CYC = `ASI_MS_CYC
) (
  // Clock and reset
  input  wire clk_i,
  input  wire rst_i,
  // Timebase outputs
  output wire ms_tick_o,
  output wire quick_tick_o,
  output wire blink_ph_o
);

  localparam [8:0] BLINK_MS = `ASI_BLINK_HALF_MS;
  localparam [6:0] QUICK_MS = `ASI_QUICK_HALF_MS;

  reg  [16:0] cyc_reg;
  reg  [8:0]  bms_reg;
  reg  [6:0]  qms_reg;
  reg         blink_reg;

  assign ms_tick_o    = (cyc_reg == MS_CYC - 17'h1);
  assign quick_tick_o = ms_tick_o && (qms_reg == QUICK_MS - 7'h1);
  assign blink_ph_o   = blink_reg;

  // ==========================================
  // Counters never stop, so every blink shares one phase
  always @(posedge clk_i) begin
    if (rst_i) begin
      cyc_reg   <= 17'h0;
      bms_reg   <= 9'h0;
      qms_reg   <= 7'h0;
      blink_reg <= 1'b0;
    end else begin
      cyc_reg <= ms_tick_o ? 17'h0 : cyc_reg + 17'h1;
      if (ms_tick_o) begin
        qms_reg <= quick_tick_o ? 7'h0 : qms_reg + 7'h1;
        if (bms_reg == BLINK_MS - 9'h1) begin
          bms_reg   <= 9'h0;
          blink_reg <= ~blink_reg;
        end else begin
          bms_reg <= bms_reg + 9'h1;
        end
      end
    end
  end

endmodule

// ### verilog/asi_indicator.v
// Front-panel indicator, display and buzzer controller with Wishbone registers
// Functional notes
// - Lock LED steady; key press blinks three
// - Extra-rinse LED on, never drain-and-spin
// - Door LED follows lock; blinks PTC unlocking
// - Door LED flashes during drum positioning
// - Invalid selection: red three quick flashes
// - Warning: start LED dark, red flashes
// - Red blink half second on/off
// - Warning status LED blinks with red
// - Start after fix restores normal LEDs
// - Time h.mm, minute steps, no leading zeros
// - Cycle end shows single steady zero
// - Invalid selection flashes Err three times
// - Faults shown as E plus code
// - Three beeps every 20 s, max 5 min
// - Fault beeps ignore buzzer disable
// - Codes E10, E20, E40 for timeouts
// - E91 link loss, EH0 mains fault
// - Start after fix restores time, beeps end
`timescale 1ns/1ps
`include "asi_defs.vh"

module asi_indicator #(
  parameter [16:0] MS_CYC = `ASI_MS_CYC
) (
  // Clock and reset
  input  wire        clk_i,
  input  wire        rst_i,
  // Wishbone slave
  input  wire        cyc_i,
  input  wire        stb_i,
  input  wire        we_i,
  input  wire [7:0]  adr_i,
  input  wire [31:0] dat_i,
  input  wire [3:0]  sel_i,
  output reg  [31:0] dat_o,
  output wire        ack_o,
  // Panel keys (pins)
  input  wire        key_any_i,
  input  wire        start_key_i,
  // LEDs
  output reg         led_lock_o,
  output reg         led_xr_o,
  output reg         led_door_o,
  output reg         led_red_o,
  output reg         led_sp_o,
  // Display and buzzer
  output reg  [20:0] seg_o,
  output reg         dp_o,
  output reg         buzzer_o,
  // Interrupt
  output wire        irq_o
);

  // ==========================================
  // Derived counts in milliseconds
  localparam [18:0] BURST_MS = `ASI_BURST_S * 1000;
  localparam [18:0] MAX_MS   = `ASI_BEEP_MAX_MIN * 60 * 1000;
  localparam [18:0] MIN_MS   = `ASI_MINUTE_S * 1000;
  localparam [18:0] BEEP_MS  = `ASI_BEEP_MS;

  // ==========================================
  // Functions
  function [15:0] wmerge;
    input [15:0] old;
    input [31:0] d;
    input [3:0]  s;
    begin
      wmerge = {s[1] ? d[15:8] : old[15:8], s[0] ? d[7:0] : old[7:0]};
    end
  endfunction

  function [6:0] seg7;
    input [3:0] c;
    begin
      case (c)
        4'h0: seg7 = 7'h3f;
        4'h1: seg7 = 7'h06;
        4'h2: seg7 = 7'h5b;
        4'h3: seg7 = 7'h4f;
        4'h4: seg7 = 7'h66;
        4'h5: seg7 = 7'h6d;
        4'h6: seg7 = 7'h7d;
        4'h7: seg7 = 7'h07;
        4'h8: seg7 = 7'h7f;
        4'h9: seg7 = 7'h6f;
        `ASI_CH_E: seg7 = 7'h79;
        `ASI_CH_R: seg7 = 7'h50;
        `ASI_CH_H: seg7 = 7'h76;
        default: seg7 = 7'h00;
      endcase
    end
  endfunction

  // BCD h.mm minus one minute
  function [10:0] tte_dec;
    input [10:0] t;
    begin
      if (t[3:0] != 4'h0) begin
        tte_dec = {t[10:4], t[3:0] - 4'h1};
      end else if (t[6:4] != 3'h0) begin
        tte_dec = {t[10:7], t[6:4] - 3'h1, 4'h9};
      end else if (t[10:7] != 4'h0) begin
        tte_dec = {t[10:7] - 4'h1, 3'h5, 4'h9};
      end else begin
        tte_dec = 11'h000;
      end
    end
  endfunction

  // ==========================================
  // Declarations
  reg  [2:0]  key_s_reg;
  reg  [2:0]  sp_s_reg;
  reg         ack_reg;
  reg  [11:0] ctrl_reg;
  reg  [2:0]  fault_reg;
  reg  [2:0]  code_reg;
  reg  [10:0] tte_reg;
  reg  [4:0]  istat_reg;
  reg  [4:0]  imask_reg;
  reg         warn_reg;
  reg  [2:0]  lock_cnt_reg;
  reg  [2:0]  inv_cnt_reg;
  reg  [18:0] min_ms_reg;
  reg  [18:0] fault_ms_reg;
  reg  [18:0] burst_ms_reg;
  reg  [3:0]  c2;
  reg  [3:0]  c1;
  reg  [3:0]  c0;
  reg         dp_next;
  reg  [31:0] rd_next;
  wire        ms_tick;
  wire        quick_tick;
  wire        blink_ph;

  // ==========================================
  // Shared timebase
  asi_timebase #(
    .MS_CYC (MS_CYC)
  ) u_tb (
    .clk_i        (clk_i),
    .rst_i        (rst_i),
    .ms_tick_o    (ms_tick),
    .quick_tick_o (quick_tick),
    .blink_ph_o   (blink_ph)
  );

  // ==========================================
  // Key synchronisers, stage 0 feeds only stage 1
  always @(posedge clk_i) begin
    if (rst_i) begin
      key_s_reg <= 3'h0;
      sp_s_reg  <= 3'h0;
    end else begin
      key_s_reg <= {key_s_reg[1:0], key_any_i};
      sp_s_reg  <= {sp_s_reg[1:0], start_key_i};
    end
  end

  wire key_ev = key_s_reg[1] & ~key_s_reg[2];
  wire sp_ev  = sp_s_reg[1] & ~sp_s_reg[2];

  // ==========================================
  // Bus decode; writes commit on the acknowledged edge
  wire       req    = cyc_i & stb_i & ~ack_reg;
  wire       hit    = (adr_i[7:5] == 3'h0);
  wire [2:0] widx   = adr_i[4:2];
  wire       wr     = cyc_i & stb_i & we_i & ack_reg & hit;
  assign ack_o = ack_reg;

  // Byte-merged write words, cut to register width on purpose
  wire [15:0] ctrl_wm = wmerge({4'h0, ctrl_reg}, dat_i, sel_i);
  wire [15:0] tte_wm  = wmerge({5'h0, tte_reg}, dat_i, sel_i);

  wire lock    = ctrl_reg[`ASI_C_LOCK];
  wire running = ctrl_reg[`ASI_C_RUN] & ~ctrl_reg[`ASI_C_PAUSE];
  wire disp    = ctrl_reg[`ASI_C_DISP];
  wire unlk    = ctrl_reg[`ASI_C_UNLK] & ctrl_reg[`ASI_C_PTC];
  wire drum    = ctrl_reg[`ASI_C_TOPDSP] & ctrl_reg[`ASI_C_DRUMPOS];

  // ==========================================
  // Events
  wire lock_ev  = key_ev & lock;
  wire inv_sw   = wr & (widx == `ASI_A_CMD) & sel_i[0] & dat_i[0];
  wire inv_ev   = inv_sw | (key_ev & ~lock & running);
  wire fault_ev = (fault_reg != `ASI_F_NONE) & ~warn_reg;
  wire clr_ev   = warn_reg & (fault_reg == `ASI_F_NONE) & sp_ev;
  wire min_step = ms_tick & (min_ms_reg == MIN_MS - 19'h1);
  wire tte_run  = running & ~warn_reg & (tte_reg != 11'h000);
  wire end_ev   = tte_run & min_step & (tte_dec(tte_reg) == 11'h000);
  wire [4:0] ev = {lock_ev, end_ev, clr_ev, fault_ev, inv_ev};
  wire [4:0] w1c = (wr & (widx == `ASI_A_ISTAT) & sel_i[0]) ? dat_i[4:0] : 5'h00;

  assign irq_o = |(istat_reg & imask_reg);

  // ==========================================
  // Registers and sticky status
  always @(posedge clk_i) begin
    if (rst_i) begin
      ack_reg   <= 1'b0;
      ctrl_reg  <= `ASI_CTRL_RST;
      fault_reg <= `ASI_F_NONE;
      imask_reg <= 5'h00;
      istat_reg <= 5'h00;
    end else begin
      ack_reg <= req;
      if (wr && widx == `ASI_A_CTRL) begin
        ctrl_reg <= ctrl_wm[11:0];
      end
      if (wr && widx == `ASI_A_FAULT && sel_i[0]) begin
        fault_reg <= dat_i[2:0];
      end
      if (wr && widx == `ASI_A_IMASK && sel_i[0]) begin
        imask_reg <= dat_i[4:0];
      end
      // New events win over a clear in the same cycle
      istat_reg <= (istat_reg & ~w1c) | ev;
    end
  end

  // ==========================================
  // Read data, answered together with ack
  always @* begin
    case (widx)
      `ASI_A_CTRL:  rd_next = {20'h0, ctrl_reg};
      `ASI_A_FAULT: rd_next = {29'h0, fault_reg};
      `ASI_A_TTE:   rd_next = {21'h0, tte_reg};
      `ASI_A_STAT:  rd_next = {27'h0, warn_reg, tte_reg == 11'h000, code_reg};
      `ASI_A_ISTAT: rd_next = {27'h0, istat_reg};
      `ASI_A_IMASK: rd_next = {27'h0, imask_reg};
      default:      rd_next = 32'h0;
    endcase
    if (!hit) begin
      rd_next = 32'h0;
    end
  end

  always @(posedge clk_i) begin
    if (rst_i) begin
      dat_o <= 32'h0;
    end else if (req && !we_i) begin
      dat_o <= rd_next;
    end
  end

  // ==========================================
  // Warning state; the code stays latched until start is pressed with no fault set
  always @(posedge clk_i) begin
    if (rst_i) begin
      warn_reg <= 1'b0;
      code_reg <= `ASI_F_NONE;
    end else if (fault_reg != `ASI_F_NONE) begin
      warn_reg <= 1'b1;
      code_reg <= fault_reg;
    end else if (sp_ev) begin
      warn_reg <= 1'b0;
      code_reg <= `ASI_F_NONE;
    end
  end

  // ==========================================
  // Remaining time; software load overrides the minute step
  always @(posedge clk_i) begin
    if (rst_i) begin
      tte_reg    <= `ASI_TTE_RST;
      min_ms_reg <= 19'h0;
    end else begin
      if (!tte_run) begin
        min_ms_reg <= 19'h0;
      end else if (ms_tick) begin
        min_ms_reg <= min_step ? 19'h0 : min_ms_reg + 19'h1;
      end
      if (wr && widx == `ASI_A_TTE) begin
        tte_reg <= tte_wm[10:0];
      end else if (tte_run && min_step) begin
        tte_reg <= tte_dec(tte_reg);
      end
    end
  end

  // ==========================================
  // Three-flash sequencers on the quick timebase
  always @(posedge clk_i) begin
    if (rst_i) begin
      lock_cnt_reg <= 3'h0;
      inv_cnt_reg  <= 3'h0;
    end else begin
      if (lock_ev) begin
        lock_cnt_reg <= `ASI_FLASH_PHASES;
      end else if (quick_tick && lock_cnt_reg != 3'h0) begin
        lock_cnt_reg <= lock_cnt_reg - 3'h1;
      end
      if (inv_ev) begin
        inv_cnt_reg <= `ASI_FLASH_PHASES;
      end else if (quick_tick && inv_cnt_reg != 3'h0) begin
        inv_cnt_reg <= inv_cnt_reg - 3'h1;
      end
    end
  end

  wire inv_on  = (inv_cnt_reg != 3'h0) & ~inv_cnt_reg[0];
  wire lock_off = (lock_cnt_reg != 3'h0) & lock_cnt_reg[0];

  // ==========================================
  // Fault beep timers start with the warning; beeps sound only while the code is displayed
  wire beeping = warn_reg & disp & (fault_ms_reg < MAX_MS);

  always @(posedge clk_i) begin
    if (rst_i || !warn_reg) begin
      fault_ms_reg <= 19'h0;
      burst_ms_reg <= 19'h0;
    end else if (ms_tick) begin
      if (fault_ms_reg < MAX_MS) begin
        fault_ms_reg <= fault_ms_reg + 19'h1;
      end
      if (burst_ms_reg == BURST_MS - 19'h1) begin
        burst_ms_reg <= 19'h0;
      end else begin
        burst_ms_reg <= burst_ms_reg + 19'h1;
      end
    end
  end

  wire beep_slot = (burst_ms_reg < BEEP_MS) |
                   ((burst_ms_reg >= 2 * BEEP_MS) & (burst_ms_reg < 3 * BEEP_MS)) |
                   ((burst_ms_reg >= 4 * BEEP_MS) & (burst_ms_reg < 5 * BEEP_MS));

  // ==========================================
  // Display characters
  always @* begin
    c2      = `ASI_CH_BLANK;
    c1      = `ASI_CH_BLANK;
    c0      = `ASI_CH_BLANK;
    dp_next = 1'b0;
    if (!disp) begin
      c0 = `ASI_CH_BLANK;
    end else if (warn_reg) begin
      c2 = `ASI_CH_E;
      case (code_reg)
        `ASI_F_E10: begin
          c1 = 4'h1;
          c0 = 4'h0;
        end
        `ASI_F_E20: begin
          c1 = 4'h2;
          c0 = 4'h0;
        end
        `ASI_F_E40: begin
          c1 = 4'h4;
          c0 = 4'h0;
        end
        `ASI_F_E91: begin
          c1 = 4'h9;
          c0 = 4'h1;
        end
        `ASI_F_EH0: begin
          c1 = `ASI_CH_H;
          c0 = 4'h0;
        end
        default: begin
          c1 = `ASI_CH_BLANK;
          c0 = `ASI_CH_BLANK;
        end
      endcase
    end else if (inv_cnt_reg != 3'h0) begin
      if (inv_on) begin
        c2 = `ASI_CH_E;
        c1 = `ASI_CH_R;
        c0 = `ASI_CH_R;
      end
    end else begin
      c0 = tte_reg[3:0];
      if (tte_reg[10:7] != 4'h0) begin
        c2      = tte_reg[10:7];
        c1      = {1'b0, tte_reg[6:4]};
        dp_next = 1'b1;
      end else if (tte_reg[6:4] != 3'h0) begin
        c1 = {1'b0, tte_reg[6:4]};
      end
    end
  end

  // ==========================================
  // Output flops
  wire blink_w = warn_reg & blink_ph;

  always @(posedge clk_i) begin
    if (rst_i) begin
      led_lock_o <= 1'b0;
      led_xr_o   <= 1'b0;
      led_door_o <= 1'b0;
      led_red_o  <= 1'b0;
      led_sp_o   <= 1'b0;
      seg_o      <= 21'h0;
      dp_o       <= 1'b0;
      buzzer_o   <= 1'b0;
    end else begin
      seg_o <= {seg7(c2), seg7(c1), seg7(c0)};
      dp_o  <= dp_next;
      // Buzzer enable is not consulted: fault beeps need only disp and the 5 min limit
      buzzer_o <= beeping & beep_slot;
      led_red_o <= warn_reg ? blink_ph : inv_on;
      led_sp_o  <= ~warn_reg & ctrl_reg[`ASI_C_SPLED];
      if (warn_reg && code_reg == `ASI_F_E20) begin
        led_lock_o <= blink_w;
      end else begin
        led_lock_o <= lock & ~lock_off;
      end
      if (warn_reg && code_reg == `ASI_F_E10) begin
        led_xr_o <= blink_w;
      end else begin
        led_xr_o <= ctrl_reg[`ASI_C_XR] & ~ctrl_reg[`ASI_C_DSPIN];
      end
      if (warn_reg && code_reg == `ASI_F_E40) begin
        led_door_o <= blink_w;
      end else if (unlk || drum) begin
        led_door_o <= blink_ph;
      end else begin
        led_door_o <= ctrl_reg[`ASI_C_DLOCK];
      end
    end
  end

endmodule

// ### verif/asi_ind_monitor.sv
// Port checker for the status indicator, bound to the top module
`timescale 1ns/1ps
module asi_ind_monitor #(
  parameter [16:0] MS_CYC = 17'h186a0
) (
  // Clock and reset
  input wire        clk_i,
  input wire        rst_i,
  // Bus
  input wire        cyc_i,
  input wire        stb_i,
  input wire        we_i,
  input wire [7:0]  adr_i,
  input wire [31:0] dat_i,
  input wire [3:0]  sel_i,
  input wire [31:0] dat_o,
  input wire        ack_o,
  // Panel
  input wire        key_any_i,
  input wire        start_key_i,
  input wire        led_lock_o,
  input wire        led_xr_o,
  input wire        led_door_o,
  input wire        led_red_o,
  input wire        led_sp_o,
  input wire [20:0] seg_o,
  input wire        dp_o,
  input wire        buzzer_o,
  input wire        irq_o
);
  // ==========================================
  // Run lengths, too long for a repetition
  reg [31:0] red_run_reg;
  reg [31:0] buz_run_reg;
  always @(posedge clk_i) begin
    if (rst_i) begin
      red_run_reg <= 32'h0;
      buz_run_reg <= 32'h0;
    end else begin
      red_run_reg <= led_red_o ? red_run_reg + 32'h1 : 32'h0;
      buz_run_reg <= buzzer_o ? buz_run_reg + 32'h1 : 32'h0;
    end
  end
  // ==========================================
  // Assertions
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  AST_ACK_PULSE: assert property (ack_o |=> !ack_o) else $error("ack held over one cycle");
  AST_ACK_WAIT: assert property (cyc_i && stb_i && !ack_o |=> ack_o) else $error("ack late");
  AST_DAT_HOLD: assert property ($changed(dat_o) |-> ack_o && !we_i) else $error("read data moved");
  AST_RED_MAX_ON: assert property (red_run_reg <= 500 * MS_CYC) else $error("red on too long");
  AST_BUZ_MAX_ON: assert property (buz_run_reg <= 100 * MS_CYC) else $error("beep too long");
  AST_BEEP_MIN: assert property ($rose(buzzer_o) |=> buzzer_o [*8]) else $error("beep too short");
  AST_BUZ_WARN: assert property (buzzer_o |-> !led_sp_o) else $error("start led lit while beeping");
  AST_DP_HOURS: assert property (dp_o |-> seg_o[20:14] != 7'h00 && seg_o[20:14] != 7'h3f)
    else $error("point without hours");
  cover property ($rose(buzzer_o));
  cover property (dp_o);
  cover property ($rose(led_red_o));
  cover property (ack_o && !we_i);
endmodule

bind asi_indicator asi_ind_monitor #(.MS_CYC(MS_CYC)) u_mon (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i),
  .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i), .dat_i(dat_i), .sel_i(sel_i), .dat_o(dat_o), .ack_o(ack_o),
  .key_any_i(key_any_i), .start_key_i(start_key_i), .led_lock_o(led_lock_o), .led_xr_o(led_xr_o),
  .led_door_o(led_door_o), .led_red_o(led_red_o), .led_sp_o(led_sp_o), .seg_o(seg_o), .dp_o(dp_o),
  .buzzer_o(buzzer_o), .irq_o(irq_o));

// ### verif/asi_panel_model.sv
// Model of the panel keys pressed by the user
`timescale 1ns/1ps
module asi_panel_model #(
  parameter HOLD = 16
) (
  // Clock
  input  wire clk_i,
  // Press requests
  input  wire press_any_i,
  input  wire press_start_i,
  // Key pins
  output reg  key_any_o = 1'b0,
  output reg  start_key_o = 1'b0
);
  // Held well past the pin synchroniser
  reg [7:0] left_reg = 8'h00;
  always @(posedge clk_i) begin
    if (press_any_i || press_start_i) begin
      key_any_o <= press_any_i;
      start_key_o <= press_start_i;
      left_reg <= HOLD;
    end else if (left_reg != 8'h00) begin
      left_reg <= left_reg - 8'h01;
    end else begin
      key_any_o <= 1'b0;
      start_key_o <= 1'b0;
    end
  end
endmodule

// ### verif/appliance_status_indicator_tb_top.sv
// Self-checking bench for the status indicator
`timescale 1ns/1ps
`define CHK(nm, e, g) begin compares++; if ((g) !== (e)) begin err_total++; \
  $display("[FAIL] %s exp %0h got %0h", nm, e, g); end end
module appliance_status_indicator_tb_top;
  typedef struct packed {logic [11:0] ctrl; logic [10:0] time_to_end; logic [2:0] led; logic [20:0] seg; logic dp;} asi_row_t;
  reg         clk_i = 1'b0;
  reg         rst_i = 1'b1;
  reg         cyc_i = 1'b0;
  reg         stb_i = 1'b0;
  reg         we_i = 1'b0;
  reg  [7:0]  adr_i = 8'h00;
  reg  [31:0] dat_i = 32'h0;
  reg         pa = 1'b0;
  reg         ps = 1'b0;
  wire [31:0] dat_o;
  wire [20:0] seg_o;
  wire        ack_o, key_any, key_st, led_lock_o, led_xr_o, led_door_o, led_red_o, led_sp_o, dp_o, buzzer_o, irq_o;
  wire [6:0]  pr = {led_xr_o, seg_o === 21'h1e6850, buzzer_o, led_door_o, led_lock_o, led_red_o, led_sp_o};
  int         err_total = 0;
  int         compares = 0;
  int         cyc_cnt = 0;
  int         rc [0:6];
  int         k, t;
  reg  [31:0] rd;
  reg  [6:0]  dg [0:9];
  reg  [13:0] ws [1:5];
  int         wl [1:5];
  asi_row_t   rows [0:3];

  always #5 clk_i = ~clk_i;

  asi_panel_model #(.HOLD(16)) u_keys (.clk_i(clk_i), .press_any_i(pa), .press_start_i(ps),
    .key_any_o(key_any), .start_key_o(key_st));
  // Short millisecond keeps the blink periods in reach
  asi_indicator #(.MS_CYC(17'h00002)) DUT (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i),
    .we_i(we_i), .adr_i(adr_i), .dat_i(dat_i), .sel_i(4'h3), .dat_o(dat_o), .ack_o(ack_o),
    .key_any_i(key_any), .start_key_i(key_st), .led_lock_o(led_lock_o), .led_xr_o(led_xr_o),
    .led_door_o(led_door_o), .led_red_o(led_red_o), .led_sp_o(led_sp_o), .seg_o(seg_o), .dp_o(dp_o),
    .buzzer_o(buzzer_o), .irq_o(irq_o));

  // ==========================================
  // Tasks
  task wb(input [7:0] a, input [31:0] d, input w);
    @(posedge clk_i);
    cyc_i <= 1'b1;
    stb_i <= 1'b1;
    we_i <= w;
    adr_i <= a;
    dat_i <= d;
    do @(posedge clk_i); while (ack_o !== 1'b1);
    rd = dat_o;
    cyc_i <= 1'b0;
    stb_i <= 1'b0;
  endtask

  task cnt(input int n);
    reg [6:0] p;
    p = pr;
    for (int i = 0; i < 7; i++) rc[i] = 0;
    repeat (n) begin
      @(posedge clk_i);
      for (int i = 0; i < 7; i++) if (pr[i] && !p[i]) rc[i]++;
      p = pr;
    end
  endtask

  task press(input s);
    @(posedge clk_i);
    ps <= s;
    pa <= !s;
    @(posedge clk_i);
    ps <= 1'b0;
    pa <= 1'b0;
    repeat (40) @(posedge clk_i);
  endtask

  task summarize;
    $display("comparisons %0d mismatches %0d", compares, err_total);
    if (err_total == 0 && compares > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  // Ceiling sits above the long wait for the second beep burst
  always @(posedge clk_i) begin
    cyc_cnt++;
    if (cyc_cnt == 95000) begin
      err_total++;
      summarize;
    end
  end

  // ==========================================
  // Sequence
  initial begin
    dg = '{7'h3f, 7'h06, 7'h5b, 7'h4f, 7'h66, 7'h6d, 7'h7d, 7'h07, 7'h7f, 7'h6f};
    ws = '{{dg[1], dg[0]}, {dg[2], dg[0]}, {dg[4], dg[0]}, {dg[9], dg[1]}, {7'h76, dg[0]}};
    wl = '{6, 2, 3, 0, 0};
    rows[0] = '{12'h801, 11'h0d9, 3'b001, {dg[1], dg[5], dg[9]}, 1'b1};
    rows[1] = '{12'h802, 11'h059, 3'b010, {7'h00, dg[5], dg[9]}, 1'b0};
    rows[2] = '{12'h806, 11'h005, 3'b000, {14'h0, dg[5]}, 1'b0};
    rows[3] = '{12'h808, 11'h000, 3'b100, {14'h0, dg[0]}, 1'b0};
    repeat (10) @(posedge clk_i);
    rst_i <= 1'b0;
    repeat (2) @(posedge clk_i);
    `CHK("outputs", 30'h0, {seg_o, dp_o, buzzer_o, led_lock_o, led_xr_o, led_door_o, led_red_o, led_sp_o, irq_o, ack_o})
    wb(8'h00, 32'h0, 1'b0);
    `CHK("ctrl", 32'h0, rd)
    wb(8'he0, 32'h0, 1'b0);
    `CHK("unmapped", 32'h0, rd)
    $display("reset test done");
    for (k = 0; k < 4; k++) begin
      wb(8'h00, {20'h0, rows[k].ctrl}, 1'b1);
      wb(8'h08, {21'h0, rows[k].time_to_end}, 1'b1);
      repeat (4) @(posedge clk_i);
      `CHK("leds", rows[k].led, {led_door_o, led_xr_o, led_lock_o})
      `CHK("seg", rows[k].seg, seg_o)
      `CHK("dp", rows[k].dp, dp_o)
    end
    $display("row test done");
    wb(8'h00, 32'h0c00, 1'b1);
    wb(8'h14, 32'h1, 1'b1);
    wb(8'h18, 32'h1, 1'b1);
    cnt(3000);
    `CHK("irq", 1'b1, irq_o)
    `CHK("red flashes", 3, rc[1])
    `CHK("no beep", 0, rc[4])
    `CHK("err text", 3, rc[5])
    wb(8'h10, 32'h1, 1'b1);
    // Clear lands on the ack edge; look one edge later
    @(posedge clk_i);
    `CHK("irq clear", 1'b0, irq_o)
    $display("invalid test done");
    for (k = 1; k < 6; k++) begin
      wb(8'h04, k, 1'b1);
      repeat (4) @(posedge clk_i);
      for (t = 0; t < 3000 && led_red_o !== 1'b0; t++) @(posedge clk_i);
      for (t = 0; t < 3000 && led_red_o !== 1'b1; t++) @(posedge clk_i);
      repeat (500) @(posedge clk_i);
      `CHK("sp dark", 1'b0, led_sp_o)
      `CHK("red on", 1'b1, led_red_o)
      `CHK("code", {7'h79, ws[k]}, seg_o)
      if (wl[k] != 0) `CHK("status on", 1'b1, pr[wl[k]])
      repeat (1000) @(posedge clk_i);
      `CHK("red off", 1'b0, led_red_o)
      if (wl[k] != 0) `CHK("status off", 1'b0, pr[wl[k]])
      if (k == 1) begin
        for (t = 0; t < 41000 && buzzer_o !== 1'b1; t++) @(posedge clk_i);
        cnt(3000);
        `CHK("beeps", 2, rc[4])
      end
      wb(8'h04, 32'h0, 1'b1);
      press(1'b1);
      `CHK("sp back", 1'b1, led_sp_o)
      `CHK("red gone", 1'b0, led_red_o)
      `CHK("time back", {14'h0, dg[0]}, seg_o)
    end
    $display("warning test done");
    wb(8'h00, 32'h0d01, 1'b1);
    press(1'b0);
    cnt(3000);
    `CHK("lock blinks", 3, rc[2])
    `CHK("no red", 0, rc[1])
    wb(8'h00, 32'h0038, 1'b1);
    cnt(2500);
    `CHK("unlock blink", 1'b1, rc[3] > 0)
    wb(8'h00, 32'h00c0, 1'b1);
    cnt(2500);
    `CHK("drum blink", 1'b1, rc[3] > 0)
    $display("door and lock test done");
    summarize;
  end
endmodule
